// File: src/sdc_pkg.sv
// constants, types and framing layout for the card command issuer
// assumes a 10 MHz core clock and a card clock made by division from it
package sdc_pkg;
    // clocking: core period and card clock period, both in ns
    localparam int CORE_CLK_NS = 100;
    localparam int CARD_CLK_NS = 800;
    localparam int HALF_CYC = CARD_CLK_NS / (2 * CORE_CLK_NS);
    localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);
    // command token layout
    localparam int FRAME_BITS = 48;
    localparam int HDR_BITS = 40;
    localparam int CRC_BITS = 7;
    localparam logic [5:0] CNT_CRC_LAST = 6'(HDR_BITS + CRC_BITS - 1);
    localparam logic [5:0] CNT_END = 6'(FRAME_BITS - 1);
    localparam logic [5:0] CNT_HDR = 6'(HDR_BITS);
    localparam logic [6:0] CRC_POLY = 7'h09;
    localparam logic [6:0] CRC_RST = 7'h00;
    // command indices with special handling
    localparam logic [5:0] IDX_APP = 6'h37;
    localparam logic [5:0] IDX_IFCOND = 6'h08;
    // card types
    localparam logic [1:0] CT_SD = 2'h0;
    localparam logic [1:0] CT_SDIO = 2'h1;
    localparam logic [1:0] CT_MMC = 2'h2;
    localparam logic [1:0] CT_CEATA = 2'h3;
    // command class bit positions
    localparam int CC_BASIC = 0;
    localparam int CC_SREAD = 1;
    localparam int CC_BREAD = 2;
    localparam int CC_SWRITE = 3;
    localparam int CC_BWRITE = 4;
    localparam int CC_ERASE = 5;
    localparam int CC_WPROT = 6;
    localparam int CC_LOCK = 7;
    localparam int CC_APP = 8;
    localparam int CC_IO = 9;
    localparam int CC_SWITCH = 10;
    localparam int CC_BITS = 12;
    // expected response kinds
    typedef enum logic [2:0] {
        RSP_NONE = 3'h0,
        RSP_R1 = 3'h1,
        RSP_R2 = 3'h2,
        RSP_R3 = 3'h3,
        RSP_R4 = 3'h4,
        RSP_R6 = 3'h6,
        RSP_R7 = 3'h7
    } sdc_rsp_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SEND = 2'b10
    } sdc_state_type;
endpackage : sdc_pkg

// File: src/sdc_crc7.sv
// serial crc7 over the command token header bits
// assumes clr and en are never high together with meaning; clr wins
`timescale 1ns/1ps
module sdc_crc7
    import sdc_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic arst_n, // async reset, active low
    input wire logic clr, // restart for a new token
    input wire logic en, // take one header bit
    input wire logic din, // header bit, msb first
    output logic [6:0] crc // running remainder
);
    logic fb;

    // feedback of the x^7 + x^3 + 1 divider
    assign fb = din ^ crc[6];

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            crc <= CRC_RST;
        else if (clr)
            crc <= CRC_RST;
        else if (en)
            crc <= {crc[5:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RST);
    end
endmodule : sdc_crc7

// File: src/sdc_cmd_issuer.sv
// card command issuer: checks, frames and shifts one command token, two for an application command (prefix first)
// assumes the card samples cmd on the rising edge of card_clk
//
// Overview of operation
// RULE_01: token is 48 bits with crc7, end bit
// RULE_02: application commands preceded automatically by prefix command
// RULE_03: card ignores stuff and reserved argument bits
// RULE_04: SD needs classes 0, 2, 4, 5, 8
// RULE_05: high capacity SD adds lock class, not 40
// RULE_06: MMC needs the basic class
// RULE_07: issue only commands of classes card reports
// RULE_08: fixed command to class mapping
// RULE_09: MMC-only commands refused for other cards
// RULE_10: SD-only commands and ACMDs refused otherwise
// RULE_11: command 8 response depends on card type
// RULE_12: CE-ATA supports its listed MMC command subset
// RULE_13: command 0 idles cards, no response
// RULE_14: command 1 answered with R3 operating conditions
// RULE_15: command 2 answered with long R2
// RULE_16: command 3 answered with R6 address
// RULE_17: command 4 loads driver stage, no response
// RULE_18: command 5 answered by I/O cards, R4
`timescale 1ns/1ps
module sdc_cmd_issuer
    import sdc_pkg::*;
(
    input wire logic core_clk, // core clock, 10 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic cmd_start, // request pulse, taken when idle
    input wire logic [5:0] cmd_index, // command index
    input wire logic [31:0] cmd_arg, // command argument
    input wire logic cmd_app, // index is an application command
    input wire logic [1:0] card_type, // SD, SDIO, MMC or CE-ATA
    input wire logic [CC_BITS-1:0] card_ccc, // classes reported by card
    input wire logic [15:0] card_rca, // address used by the prefix
    output logic cmd_busy, // token in flight
    output logic cmd_done, // pulse: token finished
    output logic cmd_reject, // pulse: request refused
    output sdc_rsp_type resp_kind, // response expected for last token
    output logic card_clk, // card clock, free running
    output logic cmd_out, // command line drive value
    output logic cmd_oe // command line drive enable
);
    typedef struct packed {
        sdc_state_type st;
        logic [2:0] div;
        logic clk;
        logic [39:0] sh;
        logic [5:0] cnt;
        logic out;
        logic oe;
        logic pend;
        logic [5:0] p_idx;
        logic [31:0] p_arg;
        logic done;
        logic rej;
        sdc_rsp_type rsp;
    } sdc_regs_type;

    sdc_regs_type s_r;
    sdc_regs_type s_nxt;
    logic [6:0] crc;
    logic crc_clr;
    logic crc_en;
    logic fall_tick;
    logic legal;

    // command class set of an index
    function automatic logic [CC_BITS-1:0] class_of(input logic [5:0] idx, input logic app);
        logic [CC_BITS-1:0] m;
        m = '0;
        if (app)
            m[CC_APP] = 1'b1; // RULE_08
        else
        begin
            unique case (idx) // RULE_08
                6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0C,
                6'h0D, 6'h0E, 6'h0F, 6'h13: m[CC_BASIC] = 1'b1;
                6'h06, 6'h22, 6'h23, 6'h24, 6'h25, 6'h32, 6'h39: m[CC_SWITCH] = 1'b1;
                6'h0B: m[CC_SREAD] = 1'b1;
                6'h10:
                begin
                    m[CC_BREAD] = 1'b1;
                    m[CC_BWRITE] = 1'b1;
                    m[CC_LOCK] = 1'b1;
                end
                6'h11, 6'h12: m[CC_BREAD] = 1'b1;
                6'h14: m[CC_SWRITE] = 1'b1;
                6'h17:
                begin
                    m[CC_BREAD] = 1'b1;
                    m[CC_BWRITE] = 1'b1;
                end
                6'h18, 6'h19, 6'h1A, 6'h1B: m[CC_BWRITE] = 1'b1;
                6'h1C, 6'h1D, 6'h1E: m[CC_WPROT] = 1'b1;
                6'h20, 6'h21, 6'h26: m[CC_ERASE] = 1'b1;
                6'h2A: m[CC_LOCK] = 1'b1;
                6'h05, 6'h27, 6'h28, 6'h34, 6'h35: m[CC_IO] = 1'b1;
                6'h37, 6'h38, 6'h3C: m[CC_APP] = 1'b1;
                default: m = '0; // unlisted index: no class gate
            endcase
        end
        return m;
    endfunction : class_of

    // whether this card type may receive the command
    function automatic logic type_ok(input logic [5:0] idx, input logic app, input logic [1:0] ct);
        logic sd_fam;
        logic ok;
        sd_fam = (ct == CT_SD) || (ct == CT_SDIO);
        ok = 1'b1;
        if (app)
            ok = sd_fam; // RULE_10
        else
        begin
            unique case (idx)
                6'h01, 6'h0B, 6'h0E, 6'h13, 6'h14, 6'h17, 6'h1A, 6'h27, 6'h28:
                    ok = !sd_fam; // RULE_09
                6'h05, 6'h20, 6'h21, 6'h22, 6'h32, 6'h34, 6'h35, 6'h39:
                    ok = sd_fam; // RULE_10
                6'h3C, 6'h3D: ok = (ct == CT_CEATA);
                default: ok = 1'b1;
            endcase
        end
        return ok;
    endfunction : type_ok

    // response the card will give, by index and card type
    function automatic sdc_rsp_type rsp_of(input logic [5:0] idx, input logic app,
                                           input logic [1:0] ct);
        sdc_rsp_type r;
        r = RSP_R1;
        if (!app)
        begin
            unique case (idx)
                6'h00: r = RSP_NONE; // RULE_13
                6'h01: r = RSP_R3; // RULE_14
                6'h02: r = RSP_R2; // RULE_15
                6'h03: r = RSP_R6; // RULE_16
                6'h04: r = RSP_NONE; // RULE_17
                6'h05: r = RSP_R4; // RULE_18
                6'h08: r = (ct == CT_SD || ct == CT_SDIO) ? RSP_R7 : RSP_R1; // RULE_11
                default: r = RSP_R1;
            endcase
        end
        return r;
    endfunction : rsp_of

    // a request passes only if the card type and its classes allow it
    always_comb
    begin
        logic [CC_BITS-1:0] m;
        m = class_of(cmd_index, cmd_app);
        legal = type_ok(cmd_index, cmd_app, card_type)
            && ((m == '0) || ((m & card_ccc) != '0)); // RULE_07
    end

    assign fall_tick = (s_r.div == HALF_LAST) && s_r.clk;
    assign crc_clr = (s_r.st == ST_IDLE) || !s_r.oe; // fresh remainder for each token of a pair
    assign crc_en = fall_tick && (s_r.st == ST_SEND) && s_r.oe && (s_r.cnt < CNT_HDR);

    sdc_crc7 u_crc
    (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .clr(crc_clr),
        .en(crc_en),
        .din(s_r.sh[39]),
        .crc(crc)
    );

    // next state: divider, request check, token shifter
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        s_nxt.rej = 1'b0;
        s_nxt.div = (s_r.div == HALF_LAST) ? 3'h0 : s_r.div + 3'h1;
        if (s_r.div == HALF_LAST)
            s_nxt.clk = !s_r.clk;
        unique case (s_r.st)
            ST_IDLE:
            begin
                if (cmd_start && !legal)
                    s_nxt.rej = 1'b1; // RULE_09
                else if (cmd_start)
                begin
                    s_nxt.st = ST_SEND;
                    s_nxt.cnt = 6'h00;
                    s_nxt.oe = 1'b0;
                    s_nxt.rsp = rsp_of(cmd_index, cmd_app, card_type);
                    if (cmd_app)
                    begin
                        // prefix goes first, the ACMD waits in p_idx/p_arg
                        s_nxt.sh = {2'b01, IDX_APP, card_rca, 16'h0000}; // RULE_02
                        s_nxt.pend = 1'b1;
                        s_nxt.p_idx = cmd_index;
                        s_nxt.p_arg = cmd_arg;
                    end
                    else
                        s_nxt.sh = {2'b01, cmd_index, cmd_arg}; // RULE_01
                end
            end
            ST_SEND:
            begin
                // the line only changes on a card clock falling edge
                if (fall_tick)
                begin
                    if (!s_r.oe)
                    begin
                        s_nxt.oe = 1'b1;
                        s_nxt.out = s_r.sh[39];
                    end
                    else if (s_r.cnt < CNT_HDR)
                    begin
                        s_nxt.sh = {s_r.sh[38:0], 1'b0};
                        s_nxt.cnt = s_r.cnt + 6'h01;
                        // last header bit enters the remainder on this edge: form its msb here
                        s_nxt.out = (s_r.cnt == CNT_HDR - 6'h01)
                            ? (crc[5] ^ (CRC_POLY[6] & (s_r.sh[39] ^ crc[6]))) : s_r.sh[38];
                    end
                    else if (s_r.cnt < CNT_CRC_LAST)
                    begin
                        s_nxt.cnt = s_r.cnt + 6'h01;
                        s_nxt.out = crc[6 - 3'(s_r.cnt - CNT_HDR) - 1]; // RULE_01
                    end
                    else if (s_r.cnt == CNT_CRC_LAST)
                    begin
                        s_nxt.cnt = CNT_END;
                        s_nxt.out = 1'b1; // RULE_01
                    end
                    else if (s_r.pend)
                    begin
                        // prefix sent, the line is released for one card clock, then the application command follows
                        s_nxt.pend = 1'b0;
                        s_nxt.oe = 1'b0;
                        s_nxt.cnt = 6'h00;
                        s_nxt.sh = {2'b01, s_r.p_idx, s_r.p_arg}; // RULE_02
                    end
                    else
                    begin
                        s_nxt.oe = 1'b0;
                        s_nxt.out = 1'b1;
                        s_nxt.st = ST_IDLE;
                        s_nxt.done = 1'b1;
                    end
                end
            end
            default: s_nxt.st = ST_IDLE;
        endcase
    end

    // state register; line idles high and released
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.out <= 1'b1;
            s_r.rsp <= RSP_NONE;
        end
        else
            s_r <= s_nxt;
    end

    assign cmd_busy = (s_r.st == ST_SEND);
    assign cmd_done = s_r.done;
    assign cmd_reject = s_r.rej;
    assign resp_kind = s_r.rsp;
    assign card_clk = s_r.clk;
    assign cmd_out = s_r.out;
    assign cmd_oe = s_r.oe;

    property p_start_bit;
        @(posedge core_clk) disable iff (!arst_n) $rose(cmd_oe) |-> !cmd_out;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("token start bit not zero"); // RULE_01

    property p_end_bit;
        @(posedge core_clk) disable iff (!arst_n) $fell(cmd_oe) |-> $past(cmd_out);
    endproperty
    a_end_bit: assert property (p_end_bit) else $error("token end bit not one"); // RULE_01

    property p_dir_bit;
        @(posedge core_clk) disable iff (!arst_n)
            $rose(cmd_oe) |-> (cmd_oe && !cmd_out)[*8] ##1 (cmd_oe && cmd_out);
    endproperty
    a_dir_bit: assert property (p_dir_bit) else $error("direction bit not one"); // RULE_01

    property p_mmc_only;
        @(posedge core_clk) disable iff (!arst_n)
            (!cmd_busy && cmd_start && !cmd_app && cmd_index == 6'h01 && card_type == CT_SD)
            |=> cmd_reject && !cmd_busy;
    endproperty
    a_mmc_only: assert property (p_mmc_only) else $error("MMC-only command sent to SD"); // RULE_09

    property p_sd_only;
        @(posedge core_clk) disable iff (!arst_n)
            (!cmd_busy && cmd_start && (cmd_app || cmd_index == 6'h05) && card_type == CT_MMC)
            |=> cmd_reject;
    endproperty
    a_sd_only: assert property (p_sd_only) else $error("SD-only command sent to MMC"); // RULE_10

    property p_prefix;
        @(posedge core_clk) disable iff (!arst_n)
            (!cmd_busy && cmd_start && cmd_app && !cmd_reject && legal)
            |=> s_r.sh[37:32] == IDX_APP && s_r.pend;
    endproperty
    a_prefix: assert property (p_prefix) else $error("application command lacks prefix"); // RULE_02

    property p_cmd8_rsp;
        @(posedge core_clk) disable iff (!arst_n)
            (!cmd_busy && cmd_start && !cmd_app && cmd_index == IDX_IFCOND && legal)
            |=> resp_kind == ((card_type == CT_MMC || card_type == CT_CEATA) ? RSP_R1 : RSP_R7);
    endproperty
    a_cmd8_rsp: assert property (p_cmd8_rsp) else $error("wrong response for command 8"); // RULE_11

    property p_class_gate;
        @(posedge core_clk) disable iff (!arst_n)
            (!cmd_busy && cmd_start && !cmd_app && cmd_index == 6'h11 && !card_ccc[CC_BREAD])
            |=> cmd_reject ##1 !cmd_busy;
    endproperty
    a_class_gate: assert property (p_class_gate) else $error("unsupported class issued"); // RULE_07

    property p_no_rsp;
        @(posedge core_clk) disable iff (!arst_n)
            (!cmd_busy && cmd_start && !cmd_app && (cmd_index == 6'h00 || cmd_index == 6'h04)
             && legal) |=> resp_kind == RSP_NONE;
    endproperty
    a_no_rsp: assert property (p_no_rsp) else $error("broadcast expects a response"); // RULE_13
endmodule : sdc_cmd_issuer

// File: tb/sdc_card_model.sv
// card side model: collects command tokens and reports its classes
// assumes the host changes cmd only as card_clk falls; nothing is driven back
`timescale 1ns/1ps
module sdc_card_model
    import sdc_pkg::*;
(
    input wire logic arst_n, // async reset, active low
    input wire logic card_clk, // card clock from host
    input wire logic cmd_out, // command line value
    input wire logic cmd_oe, // host drives the line
    input wire logic [1:0] ct, // kind of card modelled
    input wire logic hc, // high capacity sd card
    output logic [CC_BITS-1:0] ccc, // classes reported in csd
    output logic [7:0] frame_cnt, // tokens received
    output logic [47:0] last_frame, // newest token
    output logic [47:0] prev_frame, // token before it
    output logic card_idle, // set by go-idle, cleared by address publish
    output logic [15:0] dsr // driver stage register
);
    logic [46:0] shift_r;
    logic [5:0] cnt_r;
    // classes by card kind; ce-ata needs the i/o class for 39 and the app class for 60
    always_comb
        case (ct)
            CT_MMC: ccc = 12'h001;
            CT_CEATA: ccc = 12'h301;
            CT_SDIO: ccc = 12'h335;
            default: ccc = hc ? 12'h1B5 : 12'h135;
        endcase
    // a token opens on a driven low bit, sampled on the rising card clock
    always @(posedge card_clk or negedge arst_n)
        if (!arst_n)
        begin
            cnt_r <= 6'h00;
            frame_cnt <= 8'h00;
            card_idle <= 1'b1;
            dsr <= 16'h0404;
        end
        else if (cmd_oe && (cnt_r != 6'h00 || !cmd_out))
        begin
            shift_r <= {shift_r[45:0], cmd_out};
            cnt_r <= (cnt_r == 6'h2F) ? 6'h00 : cnt_r + 6'h01;
            if (cnt_r == 6'h2F)
            begin
                prev_frame <= last_frame;
                last_frame <= {shift_r, cmd_out};
                frame_cnt <= frame_cnt + 8'h01;
                // stuff bits never looked at, only index and used fields
                if (shift_r[44:39] == 6'h00)
                    card_idle <= 1'b1;
                if (shift_r[44:39] == 6'h03)
                    card_idle <= 1'b0;
                if (shift_r[44:39] == 6'h04)
                    dsr <= shift_r[38:23];
            end
        end
endmodule : sdc_card_model

// File: tb/sdc_cmd_issuer_tb.sv
// self-checking bench for the card command issuer
// assumes the card model only observes; expected tokens built here
`timescale 1ns/1ps
module sdc_cmd_issuer_tb;
    import sdc_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cmd_start = 1'b0;
    logic [5:0] cmd_index = 6'h00;
    logic [31:0] cmd_arg = 32'h0;
    logic cmd_app = 1'b0;
    logic [1:0] card_type = 2'h0;
    logic [CC_BITS-1:0] card_ccc = 12'h000;
    logic [15:0] card_rca = 16'hA5C3;
    logic cmd_busy, cmd_done, cmd_reject, card_clk, cmd_out, cmd_oe;
    sdc_rsp_type resp_kind;
    logic hc = 1'b0;
    logic use_ovr = 1'b0;
    logic [CC_BITS-1:0] ccc_ovr = 12'h000;
    logic [CC_BITS-1:0] m_ccc;
    logic [7:0] frame_cnt;
    logic [47:0] last_frame, prev_frame;
    logic [15:0] m_dsr;
    logic m_idle;
    sdc_rsp_type last_rsp = RSP_NONE;
    int errors = 0;
    int compares = 0;

    sdc_cmd_issuer dut (.core_clk(core_clk), .arst_n(arst_n), .cmd_start(cmd_start),
        .cmd_index(cmd_index), .cmd_arg(cmd_arg), .cmd_app(cmd_app), .card_type(card_type),
        .card_ccc(card_ccc), .card_rca(card_rca), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
        .cmd_reject(cmd_reject), .resp_kind(resp_kind), .card_clk(card_clk),
        .cmd_out(cmd_out), .cmd_oe(cmd_oe));
    sdc_card_model card (.arst_n(arst_n), .card_clk(card_clk), .cmd_out(cmd_out),
        .cmd_oe(cmd_oe), .ct(card_type), .hc(hc), .ccc(m_ccc), .frame_cnt(frame_cnt),
        .last_frame(last_frame), .prev_frame(prev_frame), .card_idle(m_idle), .dsr(m_dsr));

    // 10 MHz core clock
    always #50 core_clk = ~core_clk;

    task automatic report_and_stop;
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    task automatic cmp_bit(input string name, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask : cmp_bit

    task automatic cmp_rsp(input string name, input sdc_rsp_type exp, input sdc_rsp_type got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_rsp

    task automatic cmp_vec(input string name, input logic [47:0] exp, input logic [47:0] got);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_vec

    // token as it must appear on the line, crc7 over the 40 header bits
    function automatic logic [47:0] mk_frame(input logic [5:0] idx, input logic [31:0] arg);
        logic [39:0] hdr;
        logic [6:0] crc;
        logic fb;
        hdr = {2'b01, idx, arg};
        crc = 7'h00;
        for (int i = 39; i >= 0; i--)
        begin
            fb = hdr[i] ^ crc[6];
            crc = {crc[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
        end
        return {hdr, crc, 1'b1};
    endfunction : mk_frame

    // one request; card_type settles a cycle early so model classes follow it
    task automatic do_cmd(input logic [5:0] idx, input logic [31:0] arg, input logic app,
        input logic [1:0] ct, input logic rej, input sdc_rsp_type rsp);
        logic [7:0] cnt0;
        int n;
        @(posedge core_clk);
        card_type <= ct;
        @(posedge core_clk);
        card_ccc <= use_ovr ? ccc_ovr : m_ccc;
        cmd_index <= idx;
        cmd_arg <= arg;
        cmd_app <= app;
        cmd_start <= 1'b1;
        cnt0 = frame_cnt;
        @(posedge core_clk);
        cmd_start <= 1'b0;
        #1;
        cmp_bit("cmd_reject", rej, cmd_reject);
        cmp_bit("cmd_busy", !rej, cmd_busy);
        cmp_rsp("resp_kind", rej ? last_rsp : rsp, resp_kind);
        if (!rej)
            last_rsp = rsp;
        n = 0;
        while (!rej && cmd_done !== 1'b1)
        begin
            @(posedge core_clk);
            #1;
            n++;
            if (n > 1000)
            begin
                errors++;
                report_and_stop();
            end
        end
        cmp_bit("cmd_busy", 1'b0, cmd_busy);
        cmp_bit("cmd_oe", 1'b0, cmd_oe);
        cmp_bit("cmd_out", 1'b1, cmd_out);
        cmp_vec("frame_cnt", {40'h0, cnt0 + (rej ? 8'h00 : (app ? 8'h02 : 8'h01))},
            {40'h0, frame_cnt});
        if (!rej)
            cmp_vec("last_frame", mk_frame(idx, arg), last_frame);
        if (!rej && app)
            cmp_vec("prev_frame", mk_frame(IDX_APP, {card_rca, 16'h0000}), prev_frame);
        @(posedge core_clk);
        #1;
        cmp_bit("pulse", 1'b0, rej ? cmd_reject : cmd_done);
    endtask : do_cmd

    task automatic t_idle;
        cmp_bit("cmd_out", 1'b1, cmd_out);
        cmp_bit("cmd_oe", 1'b0, cmd_oe);
        cmp_bit("cmd_busy", 1'b0, cmd_busy);
        cmp_rsp("resp_kind", RSP_NONE, resp_kind);
    endtask : t_idle

    task automatic t_basic;
        do_cmd(6'h00, 32'hFFFF_FFFF, 1'b0, CT_SD, 1'b0, RSP_NONE);
        do_cmd(6'h01, 32'h00FF_8000, 1'b0, CT_MMC, 1'b0, RSP_R3);
        do_cmd(6'h02, 32'h0000_0000, 1'b0, CT_MMC, 1'b0, RSP_R2);
        do_cmd(6'h03, 32'h1234_5678, 1'b0, CT_SD, 1'b0, RSP_R6);
        cmp_bit("card_idle", 1'b0, m_idle);
        do_cmd(6'h04, 32'h5A3C_BEEF, 1'b0, CT_SD, 1'b0, RSP_NONE);
        cmp_vec("dsr", {32'h0, 16'h5A3C}, {32'h0, m_dsr});
        do_cmd(6'h05, 32'h0130_0000, 1'b0, CT_SDIO, 1'b0, RSP_R4);
        do_cmd(6'h00, 32'h0F0F_1234, 1'b0, CT_MMC, 1'b0, RSP_NONE);
        cmp_bit("card_idle", 1'b1, m_idle);
    endtask : t_basic

    task automatic t_cmd8;
        do_cmd(IDX_IFCOND, 32'h0000_01AA, 1'b0, CT_SD, 1'b0, RSP_R7);
        do_cmd(IDX_IFCOND, 32'h0000_0000, 1'b0, CT_MMC, 1'b0, RSP_R1);
    endtask : t_cmd8

    task automatic t_app_and_family;
        do_cmd(6'h29, 32'h40FF_8000, 1'b1, CT_SD, 1'b0, RSP_R1);
        do_cmd(6'h27, 32'h0001_0203, 1'b0, CT_CEATA, 1'b0, RSP_R1);
        do_cmd(6'h3C, 32'h0000_0010, 1'b0, CT_CEATA, 1'b0, RSP_R1);
        do_cmd(6'h2A, 32'h0, 1'b0, CT_SD, 1'b1, RSP_NONE);
        hc <= 1'b1;
        do_cmd(6'h2A, 32'h0, 1'b0, CT_SD, 1'b0, RSP_R1);
    endtask : t_app_and_family

    // all classes offered, so only the card type can refuse
    task automatic t_refuse;
        logic [5:0] mmc_only [9] = '{6'h01, 6'h0B, 6'h0E, 6'h13, 6'h14, 6'h17, 6'h1A,
            6'h27, 6'h28};
        logic [5:0] sd_only [8] = '{6'h05, 6'h20, 6'h21, 6'h22, 6'h32, 6'h34, 6'h35, 6'h39};
        use_ovr = 1'b1;
        ccc_ovr = 12'hFFF;
        foreach (mmc_only[i]) do_cmd(mmc_only[i], 32'h0, 1'b0, CT_SD, 1'b1, RSP_NONE);
        foreach (mmc_only[i]) do_cmd(mmc_only[i], 32'h0, 1'b0, CT_SDIO, 1'b1, RSP_NONE);
        foreach (sd_only[i]) do_cmd(sd_only[i], 32'h0, 1'b0, CT_MMC, 1'b1, RSP_NONE);
        foreach (sd_only[i]) do_cmd(sd_only[i], 32'h0, 1'b0, CT_CEATA, 1'b1, RSP_NONE);
        do_cmd(6'h29, 32'h0, 1'b1, CT_CEATA, 1'b1, RSP_NONE);
        do_cmd(6'h3D, 32'h0, 1'b0, CT_SD, 1'b1, RSP_NONE);
    endtask : t_refuse

    // class gate: a command passes if any of its classes is reported
    task automatic t_classes;
        ccc_ovr = 12'h131;
        do_cmd(6'h11, 32'h0000_0200, 1'b0, CT_SD, 1'b1, RSP_NONE);
        ccc_ovr = 12'h080;
        do_cmd(6'h10, 32'h0000_0200, 1'b0, CT_SD, 1'b0, RSP_R1);
        ccc_ovr = 12'h001;
        do_cmd(6'h10, 32'h0000_0200, 1'b0, CT_SD, 1'b1, RSP_NONE);
        ccc_ovr = 12'hEFF;
        do_cmd(IDX_APP, 32'h0, 1'b0, CT_SD, 1'b1, RSP_NONE);
        use_ovr = 1'b0;
    endtask : t_classes

    // reset held 12 cycles, then the scenarios in turn
    initial
    begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        #1;
        t_idle();
        t_basic();
        t_cmd8();
        t_app_and_family();
        t_refuse();
        t_classes();
        report_and_stop();
    end
endmodule : sdc_cmd_issuer_tb
